// *** dac_pkg.sv ***
// constants and types shared by the converter control block
package dac_pkg;
   // ==========================================================
   // sizes
   localparam int NUM_CH = 8;
   localparam int WIPER_W = 12;
   localparam int DATA_W = 16;
   localparam int IDX_W = 6;
   localparam int NV_LOCS = 11;
   localparam int NV_CNT_W = 6;
   localparam logic [NV_CNT_W-1:0] NV_MAX_WRITES = 6'h20;
   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_WIPER0 = 6'h00;
   localparam logic [IDX_W-1:0] IDX_WIPER7 = 6'h07;
   localparam logic [IDX_W-1:0] IDX_VREF = 6'h08;
   localparam logic [IDX_W-1:0] IDX_PDOWN = 6'h09;
   localparam logic [IDX_W-1:0] IDX_GAIN_STAT = 6'h0a;
   localparam logic [IDX_W-1:0] IDX_NV_FIRST = 6'h10;
   localparam logic [IDX_W-1:0] IDX_NV_LAST = 6'h1a;
   localparam logic [IDX_W-1:0] IDX_LINK_STAT = 6'h20;
   localparam logic [IDX_W-1:0] IDX_POINTER = 6'h21;
   // nv location numbers of the power-up image
   localparam logic [3:0] NV_LOC_VREF = 4'h8;
   localparam logic [3:0] NV_LOC_PDOWN = 4'h9;
   localparam logic [3:0] NV_LOC_GAIN_ADDR = 4'ha;
   // ==========================================================
   // field positions
   localparam int GAIN_LSB = 8;
   localparam int POR_FLAG_BIT = 7;
   localparam int ADDR_LSB = 0;
   // ==========================================================
   // reset and forced values
   localparam logic [WIPER_W-1:0] WIPER_MID = 12'h800;
   localparam logic [WIPER_W-1:0] WIPER_BOR = 12'h000;
   localparam logic [1:0] PD_OFF = 2'h3;
   localparam logic [DATA_W-1:0] CFG_ZERO = 16'h0000;
   localparam logic [6:0] STORED_ADDR_DEFAULT = 7'h60;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   // ==========================================================
   // timing
   localparam int CLK_FREQ_MHZ = 50;
   localparam int PORD_TIME_NS = 10000;
   localparam int PORD_CYCLES = (PORD_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int PORD_CNT_W = 16;
   // ==========================================================
   // serial client states
   typedef enum logic [1:0] {LINK_IDLE, LINK_SHIFT, LINK_ACK, LINK_IGNORE} link_state_t;
endpackage

// *** pin_sync.sv ***
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [W-1:0] pinIn,
   output logic [W-1:0] pinSync
);
   logic [W-1:0] stage1_r;

   // stage1 feeds only the second flop
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         stage1_r <= '0;
         pinSync <= '0;
      end else begin
         stage1_r <= pinIn;
         pinSync <= stage1_r;
      end
   end
endmodule
`default_nettype wire

// *** nv_store.sv ***
// few-times-programmable store with per-location write counters
`timescale 1ns/1ns
`default_nettype none
module nv_store
   import dac_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wrEn,
   input wire logic [3:0] wrLoc,
   input wire logic [DATA_W-1:0] wrData,
   input wire logic hvPresent,
   input wire logic blocked,
   output logic [NV_LOCS*DATA_W-1:0] nvData,
   output logic [NV_LOCS-1:0] nvProgrammed,
   output logic nvRefused
);
   logic [NV_CNT_W-1:0] wrCount_r [NV_LOCS];
   logic accept;

   // needs programming voltage, no brown-out, writes left
   assign accept = wrEn && hvPresent && !blocked && (int'(wrLoc) < NV_LOCS)
                   && (wrCount_r[wrLoc] < NV_MAX_WRITES);

   // ==========================================================
   // storage; logic reset clears contents, programmed flags and write counters
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         nvData <= '0;
         nvProgrammed <= '0;
         nvRefused <= 1'b0;
         for (int i = 0; i < NV_LOCS; i++) begin
            wrCount_r[i] <= '0;
         end
      end else begin
         nvRefused <= wrEn && !accept;
         if (accept) begin
            nvData[wrLoc*DATA_W +: DATA_W] <= wrData;
            nvProgrammed[wrLoc] <= 1'b1;
            wrCount_r[wrLoc] <= wrCount_r[wrLoc] + 6'h01;
         end
      end
   end
endmodule
`default_nettype wire

// *** dac_latch_ctrl.sv ***
// latch-gated output control, power reset actions and serial client pins
`timescale 1ns/1ns
`default_nettype none
module dac_latch_ctrl
   import dac_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic porPulse,
   input wire logic brownOut,
   input wire logic evenChannelLatch,
   input wire logic oddChannelLatch,
   input wire logic highVoltageProgramInput,
   input wire logic addressPinLow,
   input wire logic addressPinHigh,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOutEnN,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [NUM_CH*WIPER_W-1:0] activeWiper,
   output logic [NUM_CH*2-1:0] activeRefSelect,
   output logic [NUM_CH*2-1:0] activeTermination,
   output logic [NUM_CH-1:0] activeGain
);
   // ==========================================================
   // pins
   logic [6:0] pinsSync;
   logic latch0Sync, latch1Sync, hvSync, aLowSync, aHighSync, sclSync, sdaSync;

   pin_sync #(.W(7)) u_pins (
      .ref_clk(ref_clk),
      .reset(reset),
      .pinIn({evenChannelLatch, oddChannelLatch, highVoltageProgramInput,
              addressPinLow, addressPinHigh, sclIn, sdaIn}),
      .pinSync(pinsSync)
   );
   assign {latch0Sync, latch1Sync, hvSync, aLowSync, aHighSync, sclSync, sdaSync} = pinsSync;

   // ==========================================================
   // volatile held state and startup timer
   logic [WIPER_W-1:0] wiperHeld_r [NUM_CH];
   logic [DATA_W-1:0] refSelHeld_r, pdSelHeld_r;
   logic [NUM_CH-1:0] gainHeld_r;
   logic porFlag_r;
   logic [PORD_CNT_W-1:0] pordCnt_r;
   logic serialReady;
   logic [NV_LOCS*DATA_W-1:0] nvData;
   logic [NV_LOCS-1:0] nvProgrammed;

   // ready only after the startup delay and outside brown-out
   assign serialReady = (pordCnt_r == '0) && !brownOut;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pordCnt_r <= PORD_CNT_W'(PORD_CYCLES);
      end else if (porPulse) begin
         pordCnt_r <= PORD_CNT_W'(PORD_CYCLES);
      end else if (pordCnt_r != '0) begin
         pordCnt_r <= pordCnt_r - 16'h0001;
      end
   end

   // ==========================================================
   // bus slave: one wait cycle, then answer
   logic busAck, busWr;
   logic [IDX_W-1:0] busIdx;
   logic [31:0] rdNxt;

   assign busIdx = avs_address[7:2];
   assign busAck = (avs_read || avs_write) && !avs_waitrequest;
   assign busWr = avs_write && !avs_waitrequest;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_readdata <= rdNxt;
         end
      end
   end

   function automatic logic isWiper(input logic [IDX_W-1:0] idx);
      return idx <= IDX_WIPER7;
   endfunction

   function automatic logic isNv(input logic [IDX_W-1:0] idx);
      return (idx >= IDX_NV_FIRST) && (idx <= IDX_NV_LAST);
   endfunction

   // ==========================================================
   // serial client state (declared here, read back on the bus)
   link_state_t linkState_r;
   logic [7:0] shift_r, pointer_r, frameCnt_r;
   logic [3:0] bitCnt_r;
   logic addrPhase_r, firstData_r, sclPrev_r, sdaPrev_r;
   logic [6:0] clientAddr;

   // read mux; narrow data in low bits, rest zero
   always_comb begin
      rdNxt = 32'h00000000;
      if (isWiper(busIdx)) begin
         rdNxt[WIPER_W-1:0] = wiperHeld_r[busIdx[2:0]];
      end else if (busIdx == IDX_VREF) begin
         rdNxt[DATA_W-1:0] = refSelHeld_r;
      end else if (busIdx == IDX_PDOWN) begin
         rdNxt[DATA_W-1:0] = pdSelHeld_r;
      end else if (busIdx == IDX_GAIN_STAT) begin
         rdNxt[GAIN_LSB +: NUM_CH] = gainHeld_r;
         rdNxt[POR_FLAG_BIT] = porFlag_r;
      end else if (isNv(busIdx)) begin
         rdNxt[DATA_W-1:0] = nvData[(busIdx - IDX_NV_FIRST)*DATA_W +: DATA_W];
      end else if (busIdx == IDX_LINK_STAT) begin
         rdNxt[7:0] = frameCnt_r;
         rdNxt[14:8] = clientAddr;
         rdNxt[15] = serialReady;
      end else if (busIdx == IDX_POINTER) begin
         rdNxt[7:0] = pointer_r;
      end
   end

   // ==========================================================
   // nonvolatile store, programming voltage on the first latch pin
   nv_store u_nv (
      .ref_clk(ref_clk),
      .reset(reset),
      .wrEn(busWr && isNv(busIdx) && serialReady),
      .wrLoc(4'(busIdx - IDX_NV_FIRST)),
      .wrData(avs_writedata[DATA_W-1:0]),
      .hvPresent(hvSync),
      .blocked(brownOut),
      .nvData(nvData),
      .nvProgrammed(nvProgrammed),
      .nvRefused()
   );

   function automatic logic [DATA_W-1:0] nvWord(input logic [3:0] loc,
                                                input logic [DATA_W-1:0] dflt);
      return nvProgrammed[loc] ? nvData[loc*DATA_W +: DATA_W] : dflt;
   endfunction

   // ==========================================================
   // volatile held registers
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            wiperHeld_r[ch] <= WIPER_MID;
         end
         refSelHeld_r <= CFG_ZERO;
         pdSelHeld_r <= CFG_ZERO;
         gainHeld_r <= '0;
      end else if (brownOut) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            wiperHeld_r[ch] <= WIPER_BOR;
         end
         pdSelHeld_r <= {NUM_CH{PD_OFF}};
         refSelHeld_r <= CFG_ZERO;
         gainHeld_r <= '0;
      end else if (porPulse) begin
         // programmed store wins, else defaults; new nv values wait for this
         for (int ch = 0; ch < NUM_CH; ch++) begin
            wiperHeld_r[ch] <= WIPER_W'(nvWord(4'(ch), {4'h0, WIPER_MID}));
         end
         refSelHeld_r <= nvWord(NV_LOC_VREF, CFG_ZERO);
         pdSelHeld_r <= nvWord(NV_LOC_PDOWN, CFG_ZERO);
         gainHeld_r <= NUM_CH'(nvWord(NV_LOC_GAIN_ADDR, CFG_ZERO) >> GAIN_LSB);
      end else if (busWr && serialReady) begin
         if (isWiper(busIdx)) begin
            wiperHeld_r[busIdx[2:0]] <= avs_writedata[WIPER_W-1:0];
         end else if (busIdx == IDX_VREF) begin
            refSelHeld_r <= avs_writedata[DATA_W-1:0];
         end else if (busIdx == IDX_PDOWN) begin
            pdSelHeld_r <= avs_writedata[DATA_W-1:0];
         end else if (busIdx == IDX_GAIN_STAT) begin
            gainHeld_r <= avs_writedata[GAIN_LSB +: NUM_CH];
         end
      end
   end

   // reset flag: power-on sets it, writing zero clears; set wins
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         porFlag_r <= 1'b1;
      end else if (porPulse) begin
         porFlag_r <= 1'b1;
      end else if (busWr && serialReady && busIdx == IDX_GAIN_STAT && !avs_writedata[POR_FLAG_BIT]) begin
         porFlag_r <= 1'b0;
      end
   end

   // ==========================================================
   // latch-gated transfer to the active outputs
   // programming voltage on the shared pin counts as latch high
   function automatic logic latchOpen(input int ch, input logic l0, input logic l1, input logic hv);
      return (ch % 2 == 0) ? (!l0 && !hv) : !l1;
   endfunction

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         activeWiper <= {NUM_CH{WIPER_MID}};
         activeRefSelect <= '0;
         activeTermination <= '0;
         activeGain <= '0;
      end else begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            if (brownOut) begin
               activeWiper[ch*WIPER_W +: WIPER_W] <= WIPER_BOR;
               activeTermination[ch*2 +: 2] <= PD_OFF;
               activeRefSelect[ch*2 +: 2] <= 2'h0;
               activeGain[ch] <= 1'b0;
            end else if (latchOpen(ch, latch0Sync, latch1Sync, hvSync)) begin
               // low level copies every cycle: falling edge transfer and
               // immediate update share one path
               activeWiper[ch*WIPER_W +: WIPER_W] <= wiperHeld_r[ch];
               activeRefSelect[ch*2 +: 2] <= refSelHeld_r[ch*2 +: 2];
               activeTermination[ch*2 +: 2] <= pdSelHeld_r[ch*2 +: 2];
               activeGain[ch] <= gainHeld_r[ch];
            end
            // latch high: held writes do not reach outputs
         end
      end
   end

   // ==========================================================
   // serial client; clock is only ever an input
   // stored bits 6..2 from nv, pins override bits 1 and 0
   // process form, so a later store write still updates the address
   always_comb begin
      clientAddr = {5'(nvWord(NV_LOC_GAIN_ADDR, {9'h000, STORED_ADDR_DEFAULT}) >> (ADDR_LSB + 2)),
                    aHighSync, aLowSync};
   end

   logic sclRise, sclFall, startCond, stopCond;
   assign sclRise = sclSync && !sclPrev_r;
   assign sclFall = !sclSync && sclPrev_r;
   // data moving while clock high marks start or stop
   assign startCond = sclSync && sclPrev_r && sdaPrev_r && !sdaSync;
   assign stopCond = sclSync && sclPrev_r && !sdaPrev_r && sdaSync;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         sclPrev_r <= sclSync;
         sdaPrev_r <= sdaSync;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         linkState_r <= LINK_IDLE;
         shift_r <= 8'h00;
         bitCnt_r <= 4'h0;
         addrPhase_r <= 1'b0;
         firstData_r <= 1'b0;
         pointer_r <= POINTER_RESET;
         frameCnt_r <= 8'h00;
         sdaOut <= 1'b1;
         sdaOutEnN <= 1'b1;
      end else if (porPulse || !serialReady) begin
         // ignored during startup delay and brown-out
         linkState_r <= LINK_IDLE;
         sdaOutEnN <= 1'b1;
         if (porPulse) begin
            pointer_r <= POINTER_RESET;
         end
      end else if (startCond) begin
         linkState_r <= LINK_SHIFT;
         bitCnt_r <= 4'h0;
         addrPhase_r <= 1'b1;
         sdaOutEnN <= 1'b1;
      end else if (stopCond) begin
         linkState_r <= LINK_IDLE;
         sdaOutEnN <= 1'b1;
      end else begin
         unique case (linkState_r)
            LINK_IDLE, LINK_IGNORE: begin
               sdaOutEnN <= 1'b1;
            end
            LINK_SHIFT: begin
               if (sclRise) begin
                  shift_r <= {shift_r[6:0], sdaSync};
                  bitCnt_r <= bitCnt_r + 4'h1;
               end else if (sclFall && bitCnt_r == 4'h8) begin
                  bitCnt_r <= 4'h0;
                  if (addrPhase_r && shift_r[7:1] != clientAddr) begin
                     linkState_r <= LINK_IGNORE;
                  end else begin
                     // acknowledge driven on the falling edge
                     linkState_r <= LINK_ACK;
                     sdaOut <= 1'b0;
                     sdaOutEnN <= 1'b0;
                     if (addrPhase_r) begin
                        frameCnt_r <= frameCnt_r + 8'h01;
                        firstData_r <= 1'b1;
                     end else if (firstData_r) begin
                        pointer_r <= shift_r;
                        firstData_r <= 1'b0;
                     end
                     addrPhase_r <= 1'b0;
                  end
               end
            end
            LINK_ACK: begin
               if (sclFall) begin
                  // release only on the falling edge after the ack bit
                  sdaOut <= 1'b1;
                  sdaOutEnN <= 1'b1;
                  linkState_r <= LINK_SHIFT;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// *** dac_latch_ctrl_assertions.sv ***
// concurrent checks on the converter control ports
`timescale 1ns/1ns
`default_nettype none
module dac_latch_ctrl_checker
   import dac_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic porPulse,
   input wire logic brownOut,
   input wire logic evenChannelLatch,
   input wire logic oddChannelLatch,
   input wire logic sclIn,
   input wire logic sdaOut,
   input wire logic sdaOutEnN,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [NUM_CH*WIPER_W-1:0] activeWiper,
   input wire logic [NUM_CH*2-1:0] activeRefSelect,
   input wire logic [NUM_CH*2-1:0] activeTermination,
   input wire logic [NUM_CH-1:0] activeGain
);
   // ==========================================================
   // helper counters
   // latch pins pass a synchroniser, so allow a few cycles of settling
   logic [3:0] evenHigh_r;
   logic [3:0] oddHigh_r;
   logic [9:0] upTime_r;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         evenHigh_r <= 4'h0;
         oddHigh_r <= 4'h0;
         upTime_r <= 10'h000;
      end else begin
         evenHigh_r <= !evenChannelLatch ? 4'h0 : (evenHigh_r == 4'hf ? evenHigh_r : evenHigh_r + 4'h1);
         oddHigh_r <= !oddChannelLatch ? 4'h0 : (oddHigh_r == 4'hf ? oddHigh_r : oddHigh_r + 4'h1);
         upTime_r <= porPulse ? 10'h000 : (upTime_r == 10'h3ff ? upTime_r : upTime_r + 10'h001);
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence borHeld;
      brownOut [*2];
   endsequence
   chk_even_hold: assert property (evenHigh_r >= 4'h6 && !brownOut && !$past(brownOut) |-> $stable(activeWiper[11:0]))
      else $error("even output moved under high latch");
   chk_odd_hold: assert property (oddHigh_r >= 4'h6 && !brownOut && !$past(brownOut) |-> $stable(activeWiper[23:12]))
      else $error("odd output moved under high latch");
   chk_bor_wiper: assert property (borHeld |-> activeWiper == '0 && activeTermination == '1)
      else $error("brown-out did not force wipers and power-down");
   chk_bor_config: assert property (borHeld |-> activeRefSelect == '0 && activeGain == '0)
      else $error("brown-out did not clear reference and gain");
   chk_bor_quiet: assert property (borHeld |-> sdaOutEnN)
      else $error("serial data driven in brown-out");
   chk_startup_quiet: assert property (upTime_r < 10'h1f4 |-> sdaOutEnN)
      else $error("serial data driven during startup delay");
   chk_sda_timing: assert property ($changed(sdaOutEnN) |-> !sclIn)
      else $error("data drive changed while clock high");
   chk_drive_low: assert property (!sdaOutEnN |-> !sdaOut)
      else $error("data driven high");
   chk_read_width: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
      else $error("read data wider than sixteen bits");
   chk_reset_out: assert property ($fell(reset) |-> activeWiper == {NUM_CH{WIPER_MID}} && activeTermination == '0)
      else $error("outputs not at reset values");
endmodule
bind dac_latch_ctrl dac_latch_ctrl_checker chk_u (.*);
`default_nettype wire

// *** serial_host_model.sv ***
// behavioural two-wire host driving the serial pins
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
   output logic scl,
   output logic sda,
   input wire logic sdaOut,
   input wire logic sdaOutEnN
);
   // ==========================================================
   // open-drain line, pull-up wins when nobody pulls low
   logic hostSda;
   assign sda = hostSda & (sdaOutEnN | sdaOut);
   initial begin
      scl = 1'b1; // host alone makes the clock, idle high
      hostSda = 1'b1;
   end
   // ==========================================================
   // one byte from start to stop, 160 ns bit period
   task automatic frame(input logic [7:0] b, output logic ack);
      #7 hostSda = 1'b0;
      #40 scl = 1'b0;
      for (int i = 7; i >= -1; i--) begin
         #40 hostSda = (i < 0) ? 1'b1 : b[i]; // change only with clock low
         #40 scl = 1'b1;
         #40 ack = sda; // sample in the high phase
         #40 scl = 1'b0;
      end
      #40 hostSda = 1'b0;
      #40 scl = 1'b1;
      #40 hostSda = 1'b1;
      #80;
   endtask
endmodule
`default_nettype wire

// *** dac_latch_ctrl_tb.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module dac_latch_ctrl_tb
   import dac_pkg::*;
;
   logic ref_clk, reset, porPulse, brownOut, evenChannelLatch, oddChannelLatch, highVoltageProgramInput;
   logic addressPinLow, addressPinHigh, sclIn, sdaIn, sdaOut, sdaOutEnN, avs_read, avs_write, avs_waitrequest, ack;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [NUM_CH*WIPER_W-1:0] activeWiper;
   logic [NUM_CH*2-1:0] activeRefSelect, activeTermination;
   logic [NUM_CH-1:0] activeGain;
   int err_total, checks, cyc;
   dac_latch_ctrl dut_u (.*);
   serial_host_model host_u (.scl(sclIn), .sda(sdaIn), .sdaOut(sdaOut), .sdaOutEnN(sdaOutEnN));
   // ==========================================================
   // tasks
   task automatic summarize;
      if (err_total == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {16'h0000, d};
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 16'h0000, q);
      chk($sformatf("register %h", a), {64'h0, e}, {64'h0, q});
   endtask
   task automatic pause(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // ==========================================================
   // clock and hang limit, a full run needs under 2500 cycles
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         summarize();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      reset = 1'b1;
      porPulse = 1'b0;
      brownOut = 1'b0;
      evenChannelLatch = 1'b1;
      oddChannelLatch = 1'b1;
      highVoltageProgramInput = 1'b0;
      addressPinLow = 1'b1;
      addressPinHigh = 1'b1;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      pause(8);
      reset <= 1'b0;
      pause(2);
      chk("wiper out", {8{12'h800}}, activeWiper);
      rd(8'h28, 32'h80);
      host_u.frame(8'hc6, ack);
      chk("early ack", 96'h1, {95'h0, ack});
      wr(8'h00, 16'h0123);
      rd(8'h00, 32'h800);
      pause(520);
      wr(8'h00, 16'h0123);
      wr(8'h04, 16'h0456);
      pause(6);
      chk("held out", 24'h800800, activeWiper[23:0]);
      evenChannelLatch <= 1'b0; // latch falls only after writes end
      pause(6);
      chk("even out", 24'h800123, activeWiper[23:0]);
      oddChannelLatch <= 1'b0;
      pause(6);
      chk("odd out", 24'h456123, activeWiper[23:0]);
      wr(8'h08, 16'hffff);
      pause(6);
      chk("live out", 12'hfff, activeWiper[35:24]);
      rd(8'h08, 32'h0fff);
      wr(8'h20, 16'he4e4);
      wr(8'h24, 16'h1be4);
      wr(8'h28, 16'ha500);
      pause(6);
      chk("ref out", 16'he4e4, activeRefSelect);
      chk("term out", 16'h1be4, activeTermination);
      chk("gain out", 8'ha5, activeGain);
      rd(8'h28, 32'ha500);
      rd(8'h2c, 32'h0);
      host_u.frame(8'hc6, ack);
      chk("match ack", 96'h0, {95'h0, ack});
      addressPinLow <= 1'b0;
      pause(4);
      host_u.frame(8'hc6, ack);
      chk("pin ack", 96'h1, {95'h0, ack});
      host_u.frame(8'hc4, ack);
      chk("new ack", 96'h0, {95'h0, ack});
      highVoltageProgramInput <= 1'b1;
      pause(4);
      wr(8'h40, 16'h0abc);
      rd(8'h40, 32'h0abc);
      for (int i = 1; i <= 33; i++) wr(8'h44, i[15:0]);
      rd(8'h44, 32'h20);
      highVoltageProgramInput <= 1'b0;
      pause(4);
      wr(8'h40, 16'h0def);
      rd(8'h40, 32'h0abc);
      rd(8'h00, 32'h0123);
      porPulse <= 1'b1;
      pause(1);
      porPulse <= 1'b0;
      pause(6);
      chk("por out", 12'habc, activeWiper[11:0]);
      rd(8'h00, 32'h0abc);
      rd(8'h04, 32'h20);
      rd(8'h08, 32'h800);
      rd(8'h28, 32'h80);
      rd(8'h84, 32'h0);
      pause(520);
      brownOut <= 1'b1;
      pause(4);
      chk("bor wiper", 96'h0, activeWiper);
      chk("bor term", 16'hffff, activeTermination);
      chk("bor ref", 16'h0, activeRefSelect);
      chk("bor gain", 8'h0, activeGain);
      wr(8'h00, 16'h0555);
      rd(8'h00, 32'h0);
      host_u.frame(8'hc4, ack);
      chk("bor ack", 96'h1, {95'h0, ack});
      brownOut <= 1'b0;
      summarize();
   end
endmodule
`default_nettype wire
